// ==== logic/mlss_pkg.sv ====
// Constants and types for the maintenance line state source
package mlss_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 16;
  localparam int          SYM_W             = 10;

  // Register offsets
  localparam logic [7:0]  OFS_PHY_CONTROL_B = 8'h00;
  localparam logic [7:0]  OFS_SERVICE_CTRL  = 8'h04;
  localparam logic [7:0]  OFS_SERVICE_STAT  = 8'h08;

  // Reset values
  localparam logic [15:0] RST_PHY_CONTROL_B = 16'h0000;
  localparam logic [15:0] RST_SERVICE_CTRL  = 16'h0000;

  // Field positions
  localparam int          SEL_LSB           = 8;
  localparam int          SEL_MSB           = 10;
  localparam int          REQ_BIT           = 0;
  localparam int          STAT_STATE_LSB    = 0;
  localparam int          STAT_STATE_MSB    = 1;
  localparam int          STAT_LS_LSB       = 2;
  localparam int          STAT_LS_MSB       = 4;

  // Select field encodings
  localparam logic [2:0]  SEL_IDLE          = 3'h1;
  localparam logic [2:0]  SEL_HALT          = 3'h2;
  localparam logic [2:0]  SEL_MASTER        = 3'h3;
  localparam logic [2:0]  SEL_PASS          = 3'h6;

  // Symbol codes, one symbol pair per byte clock
  localparam logic [4:0]  SYM_QUIET         = 5'h00;
  localparam logic [4:0]  SYM_IDLE          = 5'h1F;
  localparam logic [4:0]  SYM_HALT          = 5'h04;

  // Sourced line state codes shown in status
  typedef enum logic [2:0] {
    MLSS_LS_NONE   = 3'h0,
    MLSS_LS_QUIET  = 3'h1,
    MLSS_LS_IDLE   = 3'h2,
    MLSS_LS_HALT   = 3'h3,
    MLSS_LS_MASTER = 3'h4,
    MLSS_LS_PASS   = 3'h5
  } mlss_ls_t;

  // Connection manager states
  typedef enum logic [1:0] {
    MLSS_OFF  = 2'h0,
    MLSS_HOLD = 2'h1
  } mlss_state_t;

endpackage

// ==== logic/mlss_top.sv ====
// Maintenance line state source with register port
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module mlss_top (
  input  wire logic                    CLOCK,
  input  wire logic                    NRST,
  input  wire logic [mlss_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [mlss_pkg::DATA_W-1:0] WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output logic      [mlss_pkg::DATA_W-1:0] RDATA,
  input  wire logic [mlss_pkg::SYM_W-1:0]  TX_DATA,
  output logic      [mlss_pkg::SYM_W-1:0]  TX_SYMBOLS,
  output logic                         SERVICE_ACTIVE
);
  import mlss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Line state decode
  function automatic mlss_ls_t ls_of(input logic [2:0] sel);
    mlss_ls_t r;
    r = MLSS_LS_QUIET;
    unique case (sel)
      SEL_IDLE:   r = MLSS_LS_IDLE;
      SEL_HALT:   r = MLSS_LS_HALT;
      SEL_MASTER: r = MLSS_LS_MASTER;
      SEL_PASS:   r = MLSS_LS_PASS;
      default:    r = MLSS_LS_QUIET;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic        rst_meta_reg;
  logic        rst_sync_reg;
  wire  logic  rst_n;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] phy_control_b_reg;
  logic [15:0] phy_control_b_next;
  logic [15:0] service_ctrl_reg;
  logic [15:0] service_ctrl_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  mlss_state_t state_reg;
  mlss_state_t state_next;
  logic [9:0]  tx_reg;
  logic [9:0]  tx_next;
  logic        active_reg;
  logic        active_next;
  mlss_ls_t    cur_ls;
  logic [2:0]  sel;

  assign sel    = phy_control_b_reg[SEL_MSB:SEL_LSB];
  assign cur_ls = (state_reg == MLSS_HOLD) ? ls_of(sel) : MLSS_LS_NONE;

  always_comb begin
    phy_control_b_next = phy_control_b_reg;
    service_ctrl_next  = service_ctrl_reg;
    rdata_next         = 16'h0000;
    if (WR) begin
      unique case (ADDR)
        OFS_PHY_CONTROL_B: phy_control_b_next = WDATA;
        OFS_SERVICE_CTRL:  service_ctrl_next  = {15'h0000, WDATA[REQ_BIT]};
        default:           ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        OFS_PHY_CONTROL_B: rdata_next = phy_control_b_reg;
        OFS_SERVICE_CTRL:  rdata_next = service_ctrl_reg;
        OFS_SERVICE_STAT: begin
          rdata_next[STAT_STATE_MSB:STAT_STATE_LSB] = state_reg;
          rdata_next[STAT_LS_MSB:STAT_LS_LSB]       = cur_ls;
        end
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      phy_control_b_reg <= RST_PHY_CONTROL_B;
      service_ctrl_reg  <= RST_SERVICE_CTRL;
      rdata_reg         <= 16'h0000;
    end else begin
      phy_control_b_reg <= phy_control_b_next;
      service_ctrl_reg  <= service_ctrl_next;
      rdata_reg         <= rdata_next;
    end
  end
  assign RDATA = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Connection manager state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MLSS_OFF: begin
        if (service_ctrl_reg[REQ_BIT]) begin
          state_next = MLSS_HOLD;
        end
      end
      MLSS_HOLD: begin
        if (!service_ctrl_reg[REQ_BIT]) begin
          state_next = MLSS_OFF;
        end
      end
      default: state_next = MLSS_OFF;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= MLSS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path
  always_comb begin
    tx_next     = TX_DATA;
    active_next = 1'b0;
    if (state_reg == MLSS_HOLD) begin
      active_next = 1'b1;
      unique case (cur_ls)
        MLSS_LS_IDLE:   tx_next = {SYM_IDLE, SYM_IDLE};
        MLSS_LS_HALT:   tx_next = {SYM_HALT, SYM_HALT};
        MLSS_LS_MASTER: tx_next = {SYM_HALT, SYM_QUIET};
        MLSS_LS_PASS:   tx_next = TX_DATA;
        default:        tx_next = {SYM_QUIET, SYM_QUIET};
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg     <= {SYM_QUIET, SYM_QUIET};
      active_reg <= 1'b0;
    end else begin
      tx_reg     <= tx_next;
      active_reg <= active_next;
    end
  end
  assign TX_SYMBOLS     = tx_reg;
  assign SERVICE_ACTIVE = active_reg;

endmodule
`default_nettype wire

// ==== verification/mlss_chk_assertions.sv ====
// Port checker for the maintenance line state source
`timescale 1ns/100ps
`default_nettype none
module mlss_chk
  import mlss_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic [7:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic [9:0]  TX_DATA,
  input wire logic [9:0]  TX_SYMBOLS,
  input wire logic        SERVICE_ACTIVE
);
  logic [2:0] sel_reg;
  logic       req_reg;
  logic       st_reg;
  logic       rst_meta_reg;
  logic       rst_sync_reg;
  // Same two-flop release as the design sees
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  // Mirror of select, request and state
  always_ff @(posedge CLOCK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sel_reg <= 3'h0;
      req_reg <= 1'b0;
      st_reg  <= 1'b0;
    end else begin
      if (WR && ADDR == 8'h00) sel_reg <= WDATA[10:8];
      if (WR && ADDR == 8'h04) req_reg <= WDATA[0];
      st_reg <= req_reg;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!rst_sync_reg);
  AST_ENTRY: assert property (WR && ADDR == 8'h04 && WDATA[0] |-> ##3 SERVICE_ACTIVE)
    else $error("no entry");
  AST_ACTIVE: assert property (st_reg |=> SERVICE_ACTIVE)
    else $error("not active");
  AST_QUIET: assert property (st_reg && sel_reg inside {3'h0, 3'h4, 3'h5, 3'h7} |=> TX_SYMBOLS == 10'h000)
    else $error("quiet");
  AST_IDLE: assert property (st_reg && sel_reg == SEL_IDLE |=> TX_SYMBOLS == {SYM_IDLE, SYM_IDLE})
    else $error("idle");
  AST_HALT: assert property (st_reg && sel_reg == SEL_HALT |=> TX_SYMBOLS == {SYM_HALT, SYM_HALT})
    else $error("halt");
  AST_MASTER: assert property (st_reg && sel_reg == SEL_MASTER |=> TX_SYMBOLS == {SYM_HALT, SYM_QUIET})
    else $error("master");
  AST_PASS: assert property (st_reg && sel_reg == SEL_PASS |=> TX_SYMBOLS == $past(TX_DATA))
    else $error("pass");
  AST_LEAVE: assert property (!st_reg |=> !SERVICE_ACTIVE && TX_SYMBOLS == $past(TX_DATA))
    else $error("leave");
endmodule
bind mlss_top mlss_chk chk_u (.CLOCK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .TX_DATA, .TX_SYMBOLS, .SERVICE_ACTIVE);
`default_nettype wire

// ==== verification/mlss_media_tx.sv ====
// Media transmitter model latching each sent symbol pair
`timescale 1ns/100ps
`default_nettype none
module mlss_media_tx (
  input  wire logic       clk,
  input  wire logic [9:0] line_in,
  output logic      [9:0] line_q
);
  always_ff @(posedge clk) line_q <= line_in;
endmodule
`default_nettype wire

// ==== verification/mlss_top_tb.sv ====
// Self-checking bench for the maintenance line state source
`timescale 1ns/100ps
`default_nettype none
module mlss_top_tb;
  import mlss_pkg::*;
  logic        CLOCK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000, RDATA, r;
  logic [9:0]  TX_DATA = 10'h000, TX_SYMBOLS, line_q;
  logic        SERVICE_ACTIVE;
  logic [2:0]  s;
  int          failures = 0, samples_checked = 0, cyc = 0, seed = 47960;
  always #2.5 CLOCK = ~CLOCK;
  mlss_top dut_u (.CLOCK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .TX_DATA, .TX_SYMBOLS, .SERVICE_ACTIVE);
  mlss_media_tx media_u (.clk(CLOCK), .line_in(TX_SYMBOLS), .line_q);
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 cmp(RDATA, e);
  endtask
  function automatic logic [9:0] exp_tx(logic [2:0] sel, logic [9:0] d);
    case (sel)
      3'h1: return 10'h3FF;
      3'h2: return 10'h084;
      3'h3: return 10'h080;
      3'h6: return d;
      default: return 10'h000;
    endcase
  endfunction
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(posedge CLOCK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    rd(8'h00, 16'h0000);
    rd(8'h0C, 16'h0000);
    $display("reset test done");
    wr(8'h04, 16'h0001);
    repeat (2) @(posedge CLOCK);
    #1 cmp(SERVICE_ACTIVE, 1'b1);
    cmp(TX_SYMBOLS, 10'h000);
    rd(8'h04, 16'h0001);
    rd(8'h08, 16'h0005);
    for (int i = 0; i < 16; i++) begin
      s = (i < 8) ? 3'(i) : 3'($random(seed));
      TX_DATA <= 10'($random(seed));
      wr(8'h00, {5'h00, s, 8'h00});
      @(posedge CLOCK);
      #1 cmp(TX_SYMBOLS, exp_tx(s, TX_DATA));
    end
    $display("select test done");
    wr(8'h04, 16'h0000);
    repeat (2) @(posedge CLOCK);
    #1 cmp(SERVICE_ACTIVE, 1'b0);
    cmp(TX_SYMBOLS, TX_DATA);
    rd(8'h08, 16'h0000);
    $display("exit test done");
    r = 16'($random(seed));
    wr(8'h00, r);
    rd(8'h00, r);
    $display("register test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
